// *** bench/serial_link_tx_config_regs_test.sv ***
// Self-checking bench for the link transmit configuration bank
`timescale 1ns/10ps
`include "sltc_consts.svh"
module serial_link_tx_config_regs_test;
	import sltc_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic hsel = 1'b1;
	logic [2:0] hsize = `SLTC_HSIZE_WORD;
	logic [31:0] hrdata, r;
	logic hreadyout, hresp, two_octet_padding_en, lane_code_valid, drive_boost_on;
	logic link_pll_regulator_boost, payload_scramble_on;
	logic [4:0] sample_width_bits, link_bank_number;
	logic [7:0] lane_active, link_chip_number;
	logic [3:0] conv_per_lane, drive_boost_level, lanes_up;
	logic [11:0] drive_boost_current_ua;
	logic [6:0] conv_total;
	int bad_count = 0;
	int tests_run = 0;
	// Hready is the one slave's own answer; select and size change only in the refusal test
	sltc_regs #(.LANES(8)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp,
		.two_octet_padding_en, .sample_width_bits, .lane_active, .conv_per_lane, .lane_code_valid,
		.drive_boost_level, .drive_boost_current_ua, .drive_boost_on, .link_pll_regulator_boost,
		.link_chip_number, .link_bank_number, .payload_scramble_on);
	sltc_rx_model rx (.lane_active, .conv_per_lane, .lanes_up, .conv_total);
	// 40 MHz clock
	always #12.5 hclk = ~hclk;
	task report_and_stop;
		$display("checks %0d, wrong %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// Bounded wait for hready; a hang ends the run
	task wt;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1) begin
			bad_count++;
			report_and_stop;
		end
	endtask
	// One single word transfer; outputs are looked at after the data edge
	task xfer(input logic w, input logic [6:0] idx, input logic [15:0] d);
		@(posedge hclk);
		haddr <= {23'h0, idx, 2'h0};
		hwrite <= w;
		htrans <= `SLTC_HTRANS_NONSEQ;
		wt();
		htrans <= 2'h0;
		hwdata <= {16'h0000, d};
		wt();
		r = hrdata;
		chk(32'(hresp), 32'(`SLTC_RESP_OKAY));
		@(negedge hclk);
	endtask
	task t_reset;
		xfer(0, `SLTC_IDX_PACKING, 16'h0000); chk(r, 32'h0000_0000);
		xfer(0, `SLTC_IDX_BOOST, 16'h0000); chk(r, 32'h0000_0000);
		xfer(0, `SLTC_IDX_REGULATOR, 16'h0000); chk(r, 32'h0000_0000);
		xfer(0, `SLTC_IDX_IDENT, 16'h0000); chk(r, 32'h0000_0000);
		xfer(0, `SLTC_IDX_SCRAMBLE, 16'h0000); chk(r, 32'h0000_0000);
		chk({lane_active, conv_per_lane, 3'h0, payload_scramble_on}, 32'h0000_0f40);
		chk(32'(lane_code_valid), 32'h0000_0001);
		$display("reset test done");
	endtask
	// Every documented code, then one illegal code to see it flagged
	task t_lanes;
		logic [2:0] code [3];
		logic [7:0] lanes [3];
		logic [3:0] conv [3];
		code = '{3'h0, 3'h1, 3'h4};
		lanes = '{8'h0f, 8'h03, 8'hff};
		conv = '{4'h4, 4'h8, 4'h2};
		for (int i = 0; i < 3; i++) begin
			xfer(1, `SLTC_IDX_PACKING, {8'h00, code[i], 5'h00});
			chk(32'(lane_active), 32'(lanes[i]));
			chk(32'(conv_per_lane), 32'(conv[i]));
			chk(32'(conv_total), 32'h0000_0010);
			chk(32'(lane_code_valid), 32'h0000_0001);
		end
		// Illegal code: every lane off, no converters, flag low
		xfer(1, `SLTC_IDX_PACKING, {8'h00, 3'h3, 5'h00});
		chk(32'(lane_active), 32'h0000_0000);
		chk(32'(conv_per_lane), 32'h0000_0000);
		chk(32'(conv_total), 32'h0000_0000);
		chk(32'(lane_code_valid), 32'h0000_0000);
		$display("lane test done");
	endtask
	task t_pad;
		xfer(1, `SLTC_IDX_PACKING, 16'h0100);
		chk({two_octet_padding_en, sample_width_bits}, 32'h0000_0030);
		xfer(1, `SLTC_IDX_PACKING, 16'h0000);
		chk({two_octet_padding_en, sample_width_bits}, 32'h0000_0000);
		$display("padding test done");
	endtask
	// Zero, one step and full scale of the boost level
	task t_boost;
		logic [3:0] lv [3];
		lv = '{4'h1, 4'hf, 4'h0};
		for (int i = 0; i < 3; i++) begin
			xfer(1, `SLTC_IDX_BOOST, {8'h00, lv[i], 4'h0});
			chk(32'(drive_boost_level), 32'(lv[i]));
			chk(32'(drive_boost_current_ua), 32'(lv[i]) * 32'h0000_00fa);
			chk(32'(drive_boost_on), 32'(lv[i] != 4'h0));
		end
		$display("boost test done");
	endtask
	task t_misc;
		xfer(1, `SLTC_IDX_REGULATOR, 16'h0002); chk(32'(link_pll_regulator_boost), 32'h0000_0001);
		xfer(1, `SLTC_IDX_REGULATOR, 16'h0000); chk(32'(link_pll_regulator_boost), 32'h0000_0000);
		xfer(1, `SLTC_IDX_IDENT, 16'ha51f);
		chk(32'(link_chip_number), 32'h0000_00a5);
		chk(32'(link_bank_number), 32'h0000_001f);
		xfer(1, `SLTC_IDX_SCRAMBLE, 16'h0080); chk(32'(payload_scramble_on), 32'h0000_0001);
		xfer(1, `SLTC_IDX_SCRAMBLE, 16'hff7f); chk(32'(payload_scramble_on), 32'h0000_0000);
		xfer(0, `SLTC_IDX_SCRAMBLE, 16'h0000); chk(r, 32'h0000_ff7f);
		xfer(1, 7'h4c, 16'hffff);
		xfer(0, 7'h4c, 16'h0000); chk(r, 32'h0000_0000);
		$display("misc test done");
	endtask
	// Byte-sized and deselected writes must leave the register alone
	task t_refuse;
		@(posedge hclk);
		hsize <= 3'b000;
		xfer(1, `SLTC_IDX_SCRAMBLE, 16'h0080);
		@(posedge hclk);
		hsize <= `SLTC_HSIZE_WORD;
		hsel <= 1'b0;
		xfer(1, `SLTC_IDX_SCRAMBLE, 16'h0080);
		@(posedge hclk);
		hsel <= 1'b1;
		chk(32'(payload_scramble_on), 32'h0000_0000);
		xfer(0, `SLTC_IDX_SCRAMBLE, 16'h0000); chk(r, 32'h0000_ff7f);
		$display("refusal test done");
	endtask
	// Reset in mid-run clears what was written
	task t_midreset;
		xfer(1, `SLTC_IDX_IDENT, 16'h5a0c);
		xfer(1, `SLTC_IDX_BOOST, 16'h0030);
		chk(32'(link_chip_number), 32'h0000_005a);
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		chk(32'(link_chip_number), 32'h0000_0000);
		chk(32'(link_bank_number), 32'h0000_0000);
		chk(32'(drive_boost_current_ua), 32'h0000_0000);
		chk(32'(lane_code_valid), 32'h0000_0001);
		xfer(0, `SLTC_IDX_SCRAMBLE, 16'h0000); chk(r, 32'h0000_0000);
		$display("mid-run reset test done");
	endtask
	// Reset for four cycles, then the scenarios in turn
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_lanes();
		t_pad();
		t_boost();
		t_misc();
		t_refuse();
		t_midreset();
		report_and_stop;
	end
endmodule

// *** bench/sltc_rx_model.sv ***
// Far-end receiver view of the lane layout chosen by the bank
`timescale 1ns/10ps
module sltc_rx_model (
	input wire logic [7:0] lane_active,
	input wire logic [3:0] conv_per_lane,
	output logic [3:0] lanes_up,
	output logic [6:0] conv_total
);
	// Lanes to align; powered-down lanes carry nothing, so they are not counted
	always_comb begin
		lanes_up = 4'h0;
		for (int i = 0; i < 8; i++) begin
			lanes_up = lanes_up + {3'h0, lane_active[i]};
		end
		conv_total = {3'h0, conv_per_lane} * {3'h0, lanes_up};
	end
endmodule

// *** core/sltc_boost_calc.sv ***
// Pre-emphasis current from the drive boost level
`timescale 1ns/10ps
`include "sltc_consts.svh"
module sltc_boost_calc (
	input wire logic [3:0] level,
	output logic [11:0] extra_current_ua,
	output logic boost_enabled
);
	import sltc_pkg::*;

	// Level times step; 15 steps fit in twelve bits
	always_comb begin
		extra_current_ua = 12'(level * `SLTC_BOOST_STEP_UA);
		boost_enabled = (level != 4'h0);
	end
endmodule

// *** core/sltc_consts.svh ***
// Register map, field positions and reset values of the link transmit configuration bank
`ifndef SLTC_CONSTS_SVH
`define SLTC_CONSTS_SVH
// Printed offsets are register indices; byte address is four times the index
`define SLTC_IDX_PACKING 7'h4b
`define SLTC_IDX_BOOST 7'h4d
`define SLTC_IDX_REGULATOR 7'h50
`define SLTC_IDX_IDENT 7'h51
`define SLTC_IDX_SCRAMBLE 7'h52
`define SLTC_REG_RESET 16'h0000
`define SLTC_PAD_BIT 8
`define SLTC_CPL_HI 7
`define SLTC_CPL_LO 5
`define SLTC_BOOST_HI 7
`define SLTC_BOOST_LO 4
`define SLTC_REGBOOST_BIT 1
`define SLTC_CHIP_HI 15
`define SLTC_CHIP_LO 8
`define SLTC_BANK_HI 4
`define SLTC_BANK_LO 0
`define SLTC_SCR_BIT 7
`define SLTC_CPL_FOUR 3'b000
`define SLTC_CPL_EIGHT 3'b001
`define SLTC_CPL_TWO 3'b100
`define SLTC_LANES_FOUR 8'h0f
`define SLTC_LANES_TWO 8'h03
`define SLTC_LANES_ALL 8'hff
`define SLTC_CONV_FOUR 4'h4
`define SLTC_CONV_EIGHT 4'h8
`define SLTC_CONV_TWO 4'h2
`define SLTC_SAMPLE_PAD_BITS 5'h10
// Extra driver current per boost step, in microamps (0.25 mA)
`define SLTC_BOOST_STEP_UA 12'h0fa
`define SLTC_HTRANS_NONSEQ 2'b10
`define SLTC_HSIZE_WORD 3'b010
`define SLTC_RESP_OKAY 1'b0
`endif

// *** core/sltc_lane_map.sv ***
// Converters-per-lane decode into lane power and converter count
`timescale 1ns/10ps
`include "sltc_consts.svh"
module sltc_lane_map #(
	parameter int LANES = 8
) (
	input wire logic [2:0] cpl_code,
	output logic [LANES-1:0] lane_active,
	output logic [3:0] conv_per_lane,
	output logic code_valid
);
	import sltc_pkg::*;

	// Decode tables below are written for eight lanes only
	if (LANES != 8) begin : g_lanes_bad
		$error("sltc_lane_map serves eight lanes only");
	end

	// Invalid codes power every lane down rather than guess a mapping
	always_comb begin
		lane_active = '0;
		conv_per_lane = 4'h0;
		code_valid = 1'b0;
		unique case (cpl_code)
			`SLTC_CPL_FOUR: begin
				lane_active = `SLTC_LANES_FOUR;
				conv_per_lane = `SLTC_CONV_FOUR;
				code_valid = 1'b1;
			end
			`SLTC_CPL_EIGHT: begin
				lane_active = `SLTC_LANES_TWO;
				conv_per_lane = `SLTC_CONV_EIGHT;
				code_valid = 1'b1;
			end
			`SLTC_CPL_TWO: begin
				lane_active = `SLTC_LANES_ALL;
				conv_per_lane = `SLTC_CONV_TWO;
				code_valid = 1'b1;
			end
			default: begin
				lane_active = '0;
				conv_per_lane = 4'h0;
				code_valid = 1'b0;
			end
		endcase
	end
endmodule

// *** core/sltc_pkg.sv ***
// Types shared by the link transmit configuration bank
package sltc_pkg;
	typedef logic [15:0] sltc_reg_t;
	typedef enum logic [2:0] {
		SLTC_SEL_NONE = 3'b001,
		SLTC_SEL_WRITE = 3'b010,
		SLTC_SEL_READ = 3'b100
	} sltc_phase_t;
endpackage

// *** core/sltc_regs.sv ***
// AHB-Lite register bank configuring the link transmitter
`timescale 1ns/10ps
`include "sltc_consts.svh"
// Functional notes
// - Padding bit clear packs densely; set pads each sample to 16 bits.
// - Code 000: four converters per lane, four lanes on, four off.
// - Code 001: eight converters per lane, two lanes on, six off.
// - Code 100: two converters per lane, all eight lanes on.
// - Pre-emphasis current is level times 0.25 mA; zero disables it.
// - Regulator boost bit raises link PLL regulator; clear keeps default.
// - Bits 15-8 of identifier register override the chip number.
// - Bits 4-0 of identifier register override the bank number.
// - Scrambler bit 7 enables payload scrambling; clear bypasses it.
module sltc_regs #(
	parameter int LANES = 8
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic two_octet_padding_en,
	output logic [4:0] sample_width_bits,
	output logic [LANES-1:0] lane_active,
	output logic [3:0] conv_per_lane,
	output logic lane_code_valid,
	output logic [3:0] drive_boost_level,
	output logic [11:0] drive_boost_current_ua,
	output logic drive_boost_on,
	output logic link_pll_regulator_boost,
	output logic [7:0] link_chip_number,
	output logic [4:0] link_bank_number,
	output logic payload_scramble_on
);
	import sltc_pkg::*;

	localparam int NREGS = 5;

	// Lane decode is fixed at eight lanes; refuse anything else at elaboration
	if (LANES != 8) begin : g_lanes_bad
		$error("sltc_regs serves eight lanes only");
	end

	sltc_reg_t regs_q [NREGS];
	sltc_phase_t phase_q;
	logic [2:0] widx_q;
	logic [31:0] rdata_q;
	logic [6:0] aidx;
	logic [2:0] slot;
	logic hit;
	logic take;
	logic [2:0] cpl_code;

	// Map a register index to its storage slot; NREGS means unmapped
	function automatic logic [2:0] slot_of(input logic [6:0] idx);
		logic [2:0] s;
		s = 3'(NREGS);
		unique case (idx)
			`SLTC_IDX_PACKING: s = 3'd0;
			`SLTC_IDX_BOOST: s = 3'd1;
			`SLTC_IDX_REGULATOR: s = 3'd2;
			`SLTC_IDX_IDENT: s = 3'd3;
			`SLTC_IDX_SCRAMBLE: s = 3'd4;
			default: s = 3'(NREGS);
		endcase
		return s;
	endfunction

	// Address phase decode; unmapped words read zero and ignore writes
	assign aidx = haddr[8:2];
	assign slot = slot_of(aidx);
	assign hit = (haddr[31:9] == 23'h00_0000) && (haddr[1:0] == 2'b00) && (slot != 3'(NREGS));
	assign take = hsel && hready && (htrans == `SLTC_HTRANS_NONSEQ) && (hsize == `SLTC_HSIZE_WORD);

	// Zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = `SLTC_RESP_OKAY;
	assign hrdata = rdata_q;

	// Phase tracker for the pending data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_q <= SLTC_SEL_NONE;
			widx_q <= 3'd0;
		end else if (hready) begin
			if (take && hit && hwrite) begin
				phase_q <= SLTC_SEL_WRITE;
				widx_q <= slot;
			end else if (take && hit) begin
				phase_q <= SLTC_SEL_READ;
				widx_q <= slot;
			end else begin
				phase_q <= SLTC_SEL_NONE;
				widx_q <= 3'd0;
			end
		end
	end

	// Read data captured at the address phase, valid through the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdata_q <= 32'h0000_0000;
		end else if (take && hit && !hwrite) begin
			rdata_q <= {16'h0000, regs_q[slot]};
		end else if (take) begin
			rdata_q <= 32'h0000_0000;
		end
	end

	// Register storage; reserved bits stored as written
	genvar gi;
	generate
		for (gi = 0; gi < NREGS; gi++) begin : g_reg
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					regs_q[gi] <= `SLTC_REG_RESET;
				end else if (phase_q == SLTC_SEL_WRITE && widx_q == 3'(gi)) begin
					regs_q[gi] <= hwdata[15:0];
				end
			end
		end
	endgenerate

	// Field outputs straight from register flops
	assign two_octet_padding_en = regs_q[0][`SLTC_PAD_BIT];
	// Zero width means dense packing, the sample keeps its native size
	assign sample_width_bits = two_octet_padding_en ? `SLTC_SAMPLE_PAD_BITS : 5'h00;
	assign drive_boost_level = regs_q[1][`SLTC_BOOST_HI:`SLTC_BOOST_LO];
	assign link_pll_regulator_boost = regs_q[2][`SLTC_REGBOOST_BIT];
	assign link_chip_number = regs_q[3][`SLTC_CHIP_HI:`SLTC_CHIP_LO];
	assign link_bank_number = regs_q[3][`SLTC_BANK_HI:`SLTC_BANK_LO];
	assign payload_scramble_on = regs_q[4][`SLTC_SCR_BIT];

	// Converters-per-lane field as stored
	assign cpl_code = regs_q[0][`SLTC_CPL_HI:`SLTC_CPL_LO];

	// Lane map trusts the host for legal codes and flags others
	sltc_lane_map #(
		.LANES(LANES)
	) u_lane_map (
		.cpl_code(cpl_code),
		.lane_active(lane_active),
		.conv_per_lane(conv_per_lane),
		.code_valid(lane_code_valid)
	);

	sltc_boost_calc u_boost (
		.level(drive_boost_level),
		.extra_current_ua(drive_boost_current_ua),
		.boost_enabled(drive_boost_on)
	);

	// Request and data phase steps of a write, and the request step of a read
	sequence wr_addr_s;
		take && hit && hwrite;
	endsequence

	sequence wr_data_s;
		phase_q == SLTC_SEL_WRITE;
	endsequence

	sequence rd_addr_s;
		take && hit && !hwrite;
	endsequence

	// Phase tracker is always exactly one state
	phase_onehot_a: assert property (@(posedge hclk) disable iff (!hresetn)
		$onehot(phase_q))
		else $error("phase tracker not one-hot");

	// Taken write opens its data phase on the addressed slot
	write_phase_a: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_addr_s |=> (phase_q == SLTC_SEL_WRITE && widx_q == $past(slot)))
		else $error("write data phase not opened");

	// Taken read opens a read data phase
	read_phase_a: assert property (@(posedge hclk) disable iff (!hresetn)
		rd_addr_s |=> (phase_q == SLTC_SEL_READ))
		else $error("read data phase not opened");

	// Refused or idle cycles leave no data phase pending
	refused_idle_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(hready && !(take && hit)) |=> (phase_q == SLTC_SEL_NONE))
		else $error("refused transfer opened a data phase");

	// Whole low half-word lands, reserved bits included
	write_word_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(wr_addr_s ##1 wr_data_s) |=> (regs_q[$past(widx_q)] == $past(hwdata[15:0])))
		else $error("written word not stored");

	// Storage only moves in a write data phase
	hold_no_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(phase_q != SLTC_SEL_WRITE) |=> ($stable(regs_q[0]) && $stable(regs_q[1]) && $stable(regs_q[2])
		&& $stable(regs_q[3]) && $stable(regs_q[4])))
		else $error("register changed without a write");

	// Read returns stored word; a write landing on the same edge is not yet seen
	read_returns_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(take && hit && !hwrite && phase_q != SLTC_SEL_WRITE) |=> (hrdata[15:0] == regs_q[$past(slot)]))
		else $error("read data mismatch");

	// Unmapped words read as zero
	unmapped_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(take && !hit) |=> (hrdata == 32'h0000_0000))
		else $error("unmapped word did not read zero");

	// Read data stands until the next taken transfer
	rdata_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!take |=> $stable(hrdata))
		else $error("read data moved without a transfer");

	// Registers are half-words; the upper bus half is always zero
	read_upper_a: assert property (@(posedge hclk) disable iff (!hresetn)
		hrdata[31:16] == 16'h0000)
		else $error("upper read bits not zero");

	// Padding bit reaches its output the cycle after the data phase
	pad_lands_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(phase_q == SLTC_SEL_WRITE && widx_q == 3'h0) |=> (two_octet_padding_en == $past(hwdata[`SLTC_PAD_BIT])))
		else $error("padding bit not stored");

	// Converters-per-lane code lands the same way
	cpl_lands_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(phase_q == SLTC_SEL_WRITE && widx_q == 3'h0) |=> (cpl_code == $past(hwdata[`SLTC_CPL_HI:`SLTC_CPL_LO])))
		else $error("lane code not stored");

	// Boost level lands from its field
	boost_lands_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(phase_q == SLTC_SEL_WRITE && widx_q == 3'h1) |=>
		(drive_boost_level == $past(hwdata[`SLTC_BOOST_HI:`SLTC_BOOST_LO])))
		else $error("boost level not stored");

	// Regulator boost bit lands from its field
	reg_boost_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(phase_q == SLTC_SEL_WRITE && widx_q == 3'h2) |=> (link_pll_regulator_boost == $past(hwdata[1])))
		else $error("regulator boost not stored");

	// Both identifier overrides land from one write
	ident_fields_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(phase_q == SLTC_SEL_WRITE && widx_q == 3'h3) |=>
		(link_chip_number == $past(hwdata[15:8]) && link_bank_number == $past(hwdata[4:0])))
		else $error("identifier override not stored");

	// Write in data phase lands one cycle later
	write_lands_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(phase_q == SLTC_SEL_WRITE && widx_q == 3'h4) |=> (payload_scramble_on == $past(hwdata[7])))
		else $error("scrambler bit not updated by write");

	// Lane layout for each legal code
	lanes_four_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(cpl_code == 3'b000) |-> (lane_active == 8'h0f && conv_per_lane == 4'h4))
		else $error("four per lane mapping wrong");

	lanes_eight_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(cpl_code == 3'b001) |-> (lane_active == 8'h03 && conv_per_lane == 4'h8))
		else $error("eight per lane mapping wrong");

	lanes_two_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(cpl_code == 3'b100) |-> (lane_active == 8'hff && conv_per_lane == 4'h2))
		else $error("two per lane mapping wrong");

	// Valid flag follows exactly the three legal codes
	lane_valid_a: assert property (@(posedge hclk) disable iff (!hresetn)
		lane_code_valid == (cpl_code == 3'b000 || cpl_code == 3'b001 || cpl_code == 3'b100))
		else $error("lane code valid flag wrong");

	// Illegal codes power every lane down
	lane_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!lane_code_valid |-> (lane_active == 8'h00 && conv_per_lane == 4'h0))
		else $error("illegal lane code left lanes on");

	// Extra current is level times a quarter milliamp
	boost_current_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(drive_boost_current_ua == 12'(drive_boost_level * 250)) && (drive_boost_on == (drive_boost_level != 0)))
		else $error("pre-emphasis current wrong");

	// Level zero means no pre-emphasis at all
	boost_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(drive_boost_level == 4'h0) |-> (!drive_boost_on && drive_boost_current_ua == 12'h000))
		else $error("pre-emphasis on at level zero");

	pad_width_a: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(two_octet_padding_en) |-> sample_width_bits == 5'h10)
		else $error("padding width not 16");

	// Padding and dense widths hold for as long as the bit does
	pad_on_a: assert property (@(posedge hclk) disable iff (!hresetn)
		two_octet_padding_en |-> (sample_width_bits == 5'h10))
		else $error("padded width wrong");

	pad_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!two_octet_padding_en |-> (sample_width_bits == 5'h00))
		else $error("dense width wrong");

	// First edge after reset sees cleared storage and an idle bus side
	reset_clear_a: assert property (@(posedge hclk)
		$rose(hresetn) |-> (regs_q[0] == `SLTC_REG_RESET && regs_q[1] == `SLTC_REG_RESET
		&& regs_q[2] == `SLTC_REG_RESET && regs_q[3] == `SLTC_REG_RESET && regs_q[4] == `SLTC_REG_RESET
		&& phase_q == SLTC_SEL_NONE && hrdata == 32'h0000_0000))
		else $error("fields not cleared by reset");

	// Cleared storage gives the documented start-up link layout
	reset_outputs_a: assert property (@(posedge hclk)
		$rose(hresetn) |-> (lane_active == 8'h0f && conv_per_lane == 4'h4 && !two_octet_padding_en
		&& !drive_boost_on && !link_pll_regulator_boost && link_chip_number == 8'h00
		&& link_bank_number == 5'h00 && !payload_scramble_on))
		else $error("outputs not at reset layout");
endmodule
